// ---- core/psp_core.sv ----
/*
 Processor state and protection core: datapath registers, arithmetic
 flags, supervisor mode, guarded memory requests and an AHB-Lite slave.
 Assumes one memory module that accepts a request when mem_ready is high,
 and an instruction sequencer driving the step inputs on this clock.
 Assumes a bus master that copes with zero wait states, and a sequencer
 that never requests while a request is held, since that one is dropped.
*/
// The AHB-Lite slave port and the address map were decided locally.
// How it works
// - A 9-bit protection register holds complemented legal upper address bits.
// - In protection mode, a nonzero upper-bits AND mask flags error, blocks cycle.
// - In user mode, upper nine address bits sent out are relocation OR original bits.
// - Carry out of bit 0 sets the carry-zero flag.
// - Carry out of bit 1 sets the carry-one flag.
// - Result sign inconsistent with operand signs sets overflow flag.
// - Jump or skip moving the counter anywhere other than up by one sets jump flag.
// - Supervisor mode reaches all memory, no protection or relocation.
// - User mode confines references to protected, relocated area.
// - In user mode, illegal reference, I/O or halt sets supervisor mode.
// - Indicator register loads data whenever a read's unrelocated address equals the switch address.
// - End of instruction writes arithmetic and/or quotient registers to memory.
// - A 36-bit quotient register extends the arithmetic register to 72 bits.
// - A 9-bit step counter holds repeat counts of iterated steps.
// - An 18-bit instruction register holds opcode, accumulator, indirect, index.
// - The 36-bit memory buffer receives memory read data and supplies the addend.
// - A 9-bit floating exponent register keeps intermediate exponents.
// - An 18-bit program counter addresses the next instruction.
`timescale 1ns/1ps
`default_nettype none
module psp_core
   import psp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   // Sequencer steps
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [WORD_W-1:0] mem_rdata,
   input wire logic load_instr,
   input wire psp_op_e op,
   input wire logic step_load,
   input wire logic [8:0] step_value,
   input wire logic fexp_load,
   input wire logic [8:0] fexp_value,
   input wire logic pc_step,
   input wire logic [ADDR_W-1:0] pc_target,
   input wire logic pc_skip,
   input wire logic pc_jump,
   input wire logic io_attempt,
   input wire logic halt_attempt,
   input wire logic end_instr,
   input wire logic store_arith,
   input wire logic store_mq,
   // Memory bus
   input wire logic mem_ready,
   output psp_mreq_s mreq,
   output logic mem_error
);
   logic [31:0] ctrl;
   logic [PAGE_W-1:0] protection_mask_reg;
   logic [PAGE_W-1:0] relocation_reg;
   // Sticky event bits and their interrupt enables
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] mask;
   // Console address watched by the indicator register
   logic [ADDR_W-1:0] sw_addr;

   // Datapath registers
   logic [WORD_W-1:0] mem_buffer_reg;
   logic [WORD_W-1:0] arith_reg;
   logic [WORD_W-1:0] mult_quot_reg;
   logic [WORD_W-1:0] mem_indicator_reg;
   logic [ADDR_W-1:0] program_counter;
   // Logical address of the last issued request, before relocation
   logic [ADDR_W-1:0] mem_addr_reg;
   psp_instr_s instr_reg;
   logic [8:0] step_counter;
   logic [8:0] float_exponent_reg;

   // Processor flags and mode
   logic carry_zero_flag;
   logic carry_one_flag;
   logic overflow_flag;
   logic counter_jump_flag;
   logic supervisor_flipflop;
   // Quotient word still owed by a double writeback
   logic wb_pend;

   // Bus data phase
   logic d_wr;
   logic d_rd;
   logic [7:0] d_addr;

   // Upper four bits of a 36-bit word, right aligned for the bus
   function automatic logic [31:0] hi_word(input logic [WORD_W-1:0] w);
      hi_word = {28'h000_0000, w[WORD_W-1:32]};
   endfunction

   // Address phase qualifier; register writes decode the data phase
   wire logic a_valid = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire logic wr_ctrl = d_wr & (d_addr == OFF_CTRL);
   wire logic wr_prot = d_wr & (d_addr == OFF_PROT);
   wire logic wr_reloc = d_wr & (d_addr == OFF_RELOC);
   wire logic wr_status = d_wr & (d_addr == OFF_STATUS);
   wire logic wr_mask = d_wr & (d_addr == OFF_MASK);
   wire logic wr_swaddr = d_wr & (d_addr == OFF_SWADDR);
   // Relocation follows user mode even when protection is off
   wire logic prot_en = ctrl[CTRL_PROT_EN_BIT];
   wire logic user_mode = ~supervisor_flipflop;

   // Guard
   logic violation;
   logic [ADDR_W-1:0] phys_addr;
   psp_guard psp_guard_i (
      .addr_in(mem_addr),
      .prot_mask(protection_mask_reg),
      .reloc(relocation_reg),
      .user_mode(user_mode),
      .prot_en(prot_en),
      .violation(violation),
      .addr_out(phys_addr)
   );

   // Arithmetic: bit 0 is the sign (MSB), bit 35 the least significant
   wire logic sub_op = (op == PSP_OP_SUB);
   wire logic [WORD_W-1:0] addend = sub_op ? ~mem_buffer_reg : mem_buffer_reg;
   wire logic [WORD_W-1:0] low_a = {2'b00, arith_reg[WORD_W-3:0]};
   wire logic [WORD_W-1:0] low_b = {2'b00, addend[WORD_W-3:0]};
   wire logic [WORD_W-1:0] low_sum = low_a + low_b + {35'h0_0000_0000, sub_op};
   wire logic c_into1 = low_sum[WORD_W-2];
   wire logic b1 = arith_reg[WORD_W-2] ^ addend[WORD_W-2] ^ c_into1;
   wire logic c_out1 = (arith_reg[WORD_W-2] & addend[WORD_W-2])
      | (c_into1 & (arith_reg[WORD_W-2] ^ addend[WORD_W-2]));
   wire logic b0 = arith_reg[WORD_W-1] ^ addend[WORD_W-1] ^ c_out1;
   wire logic c_out0 = (arith_reg[WORD_W-1] & addend[WORD_W-1])
      | (c_out1 & (arith_reg[WORD_W-1] ^ addend[WORD_W-1]));
   wire logic [WORD_W-1:0] sum = {b0, b1, low_sum[WORD_W-3:0]};
   wire logic is_arith = (op == PSP_OP_ADD) | sub_op;
   wire logic set_cry0 = is_arith & c_out0;
   wire logic set_cry1 = is_arith & c_out1;
   wire logic set_ov = is_arith & (c_out0 ^ c_out1);

   logic [WORD_W-1:0] next_arith;
   logic [WORD_W-1:0] next_mq;
   always_comb begin
      next_arith = arith_reg;
      next_mq = mult_quot_reg;
      case (op)
         PSP_OP_ADD, PSP_OP_SUB: next_arith = sum;
         PSP_OP_AND: next_arith = arith_reg & mem_buffer_reg;
         // Double-length shift across arithmetic and quotient registers
         PSP_OP_SHIFT: {next_arith, next_mq} = {arith_reg, mult_quot_reg} << 1;
         PSP_OP_LOADQ: next_mq = mem_buffer_reg;
         default: next_arith = arith_reg;
      endcase
   end

   // Memory request: no request when the guard trips
   wire logic issue = mem_req & ~violation;
   wire logic user_trap = user_mode & ((mem_req & violation) | io_attempt
      | halt_attempt);
   wire logic wb_issue = end_instr & (store_arith | store_mq);
   // A jump that lands on pc+1 is not a change
   wire logic [ADDR_W-1:0] next_pc = pc_jump ? pc_target
      : program_counter + (pc_skip ? 18'h0_0002 : 18'h0_0001);
   wire logic big_step = pc_step & (pc_jump ? (pc_target != program_counter + 18'h0_0001)
      : pc_skip);
   wire logic [EV_W-1:0] events = {set_ov, set_cry0 | set_cry1, user_trap,
      mem_req & violation};
   wire logic rd_ind_hi = (d_addr == OFF_IND_HI);

   // Address phase kept for the data phase that follows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         d_wr <= 1'b0;
         d_rd <= 1'b0;
         d_addr <= 8'h00;
      end else begin
         d_wr <= a_valid & hwrite;
         d_rd <= a_valid & ~hwrite;
         d_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= 32'h0000_0001;
         protection_mask_reg <= PAGE_RESET;
         relocation_reg <= PAGE_RESET;
         mask <= 4'h0;
         sw_addr <= 18'h0_0000;
      end else begin
         if (wr_ctrl) ctrl <= {30'h0000_0000, hwdata[1:0]};
         if (wr_prot) protection_mask_reg <= hwdata[PAGE_W-1:0];
         if (wr_reloc) relocation_reg <= hwdata[PAGE_W-1:0];
         if (wr_mask) mask <= hwdata[EV_W-1:0];
         if (wr_swaddr) sw_addr <= hwdata[ADDR_W-1:0];
      end
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) status <= 4'h0;
      else status <= (status & ~(wr_status ? hwdata[EV_W-1:0] : 4'h0)) | events;
   end

   // Out of reset in supervisor mode; a trap beats a software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) supervisor_flipflop <= 1'b1;
      else if (user_trap) supervisor_flipflop <= 1'b1;
      else if (wr_ctrl) supervisor_flipflop <= hwdata[CTRL_SUPER_BIT];
   end

   // Flags are sticky; only reset clears them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carry_zero_flag <= 1'b0;
         carry_one_flag <= 1'b0;
         overflow_flag <= 1'b0;
         counter_jump_flag <= 1'b0;
      end else begin
         if (set_cry0) carry_zero_flag <= 1'b1;
         if (set_cry1) carry_one_flag <= 1'b1;
         if (set_ov) overflow_flag <= 1'b1;
         if (big_step) counter_jump_flag <= 1'b1;
      end
   end

   // Arithmetic and quotient follow the op on every edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arith_reg <= WORD_RESET;
         mult_quot_reg <= WORD_RESET;
         mem_buffer_reg <= WORD_RESET;
      end else begin
         arith_reg <= next_arith;
         mult_quot_reg <= next_mq;
         if (mem_ack) mem_buffer_reg <= mem_rdata;
      end
   end

   // Step counter runs down while an iterated op is active
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         program_counter <= 18'h0_0000;
         instr_reg <= '0;
         step_counter <= 9'h000;
         float_exponent_reg <= 9'h000;
         mem_indicator_reg <= WORD_RESET;
      end else begin
         if (pc_step) program_counter <= next_pc;
         if (load_instr) instr_reg <= mem_buffer_reg[WORD_W-1:ADDR_W];
         if (step_load) step_counter <= step_value;
         else if (step_counter != 9'h000 && op != PSP_OP_NONE)
            step_counter <= step_counter - 9'h001;
         if (fexp_load) float_exponent_reg <= fexp_value;
         if (mem_ack && mem_addr_reg == sw_addr) mem_indicator_reg <= mem_rdata;
      end
   end

   // Memory request register; writeback takes arithmetic then quotient
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mreq <= '0;
         mem_addr_reg <= 18'h0_0000;
         mem_error <= 1'b0;
         wb_pend <= 1'b0;
      end else begin
         mem_error <= mem_req & violation;
         if (mreq.valid && !mem_ready) begin
            mreq <= mreq; // Hold until the module accepts
         end else if (issue) begin
            mreq.valid <= 1'b1;
            mreq.write <= mem_write;
            mreq.addr <= phys_addr;
            mreq.data <= arith_reg;
            mem_addr_reg <= mem_addr;
         end else if (wb_issue || wb_pend) begin
            mreq.valid <= 1'b1;
            mreq.write <= 1'b1;
            // Accumulators sit in the low page, so only relocation applies
            mreq.addr <= {(user_mode ? relocation_reg : PAGE_RESET), 5'h00,
               instr_reg.acc};
            mreq.data <= (wb_issue && store_arith) ? arith_reg
               : mult_quot_reg;
            wb_pend <= wb_issue & store_arith & store_mq;
         end else begin
            mreq.valid <= 1'b0;
         end
      end
   end

   // Level output; software clears by writing ones to status
   assign irq = |(status & mask);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Read mux; unmapped offsets read as zero
   always_comb begin
      hrdata = 32'h0000_0000;
      if (d_rd) begin
         case (d_addr)
            OFF_CTRL: hrdata = {30'h0000_0000, prot_en, supervisor_flipflop};
            OFF_PROT: hrdata = {23'h00_0000, protection_mask_reg};
            OFF_RELOC: hrdata = {23'h00_0000, relocation_reg};
            OFF_STATUS: hrdata = {28'h000_0000, status};
            OFF_MASK: hrdata = {28'h000_0000, mask};
            OFF_FLAGS: hrdata = {28'h000_0000, counter_jump_flag, overflow_flag,
               carry_one_flag, carry_zero_flag};
            OFF_PC: hrdata = {14'h0000, program_counter};
            OFF_INSTR: hrdata = {14'h0000, instr_reg};
            OFF_STEP: hrdata = {23'h00_0000, step_counter};
            OFF_FEXP: hrdata = {23'h00_0000, float_exponent_reg};
            OFF_SWADDR: hrdata = {14'h0000, sw_addr};
            OFF_IND_LO: hrdata = mem_indicator_reg[31:0];
            OFF_ARITH_LO: hrdata = arith_reg[31:0];
            OFF_ARITH_HI: hrdata = hi_word(arith_reg);
            OFF_MQ_LO: hrdata = mult_quot_reg[31:0];
            OFF_MQ_HI: hrdata = hi_word(mult_quot_reg);
            default: hrdata = rd_ind_hi ? hi_word(mem_indicator_reg) : 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- core/psp_guard.sv ----
/*
 Address guard: protection check and relocation of the upper page bits.
 Assumes the caller qualifies the request; mode selection is applied here from user_mode.
*/
`timescale 1ns/1ps
`default_nettype none
module psp_guard
   import psp_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [PAGE_W-1:0] prot_mask,
   input wire logic [PAGE_W-1:0] reloc,
   input wire logic user_mode,
   input wire logic prot_en,
   output logic violation,
   output logic [ADDR_W-1:0] addr_out
);
   wire logic [PAGE_W-1:0] page = addr_in[ADDR_W-1:OFF_W];
   wire logic [PAGE_W-1:0] hit = page & prot_mask;
   // Check uses the unrelocated page so relocation cannot hide a fault
   assign violation = user_mode & prot_en & (|hit);
   assign addr_out = user_mode ?
      {page | reloc, addr_in[OFF_W-1:0]} : addr_in;
endmodule
`default_nettype wire

// ---- core/psp_pkg.sv ----
/*
 Package for the processor state and protection block: register map,
 field layouts, reset values and shared types.
 Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
*/
package psp_pkg;
   localparam int ADDR_W = 18;
   localparam int WORD_W = 36;
   localparam int PAGE_W = 9;
   localparam int OFF_W = ADDR_W - PAGE_W;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PROT = 8'h04;
   localparam logic [7:0] OFF_RELOC = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_MASK = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;
   localparam logic [7:0] OFF_PC = 8'h18;
   localparam logic [7:0] OFF_INSTR = 8'h1C;
   localparam logic [7:0] OFF_STEP = 8'h20;
   localparam logic [7:0] OFF_FEXP = 8'h24;
   localparam logic [7:0] OFF_SWADDR = 8'h28;
   localparam logic [7:0] OFF_IND_LO = 8'h2C;
   localparam logic [7:0] OFF_IND_HI = 8'h30;
   localparam logic [7:0] OFF_ARITH_LO = 8'h34;
   localparam logic [7:0] OFF_ARITH_HI = 8'h38;
   localparam logic [7:0] OFF_MQ_LO = 8'h3C;
   localparam logic [7:0] OFF_MQ_HI = 8'h40;

   // Control register fields
   localparam int CTRL_SUPER_BIT = 0;
   localparam int CTRL_PROT_EN_BIT = 1;

   // Status/mask bits
   localparam int EV_VIOL = 0;
   localparam int EV_TRAP = 1;
   localparam int EV_CARRY = 2;
   localparam int EV_OVF = 3;
   localparam int EV_W = 4;

   // Flag register fields
   localparam int FL_CRY0 = 0;
   localparam int FL_CRY1 = 1;
   localparam int FL_OV = 2;
   localparam int FL_JUMP = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [PAGE_W-1:0] PAGE_RESET = 9'h000;
   localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;

   // Operations issued by the sequencer
   typedef enum logic [2:0] {
      PSP_OP_NONE  = 3'b000,
      PSP_OP_ADD   = 3'b001,
      PSP_OP_SUB   = 3'b011,
      PSP_OP_AND   = 3'b010,
      PSP_OP_SHIFT = 3'b110,
      PSP_OP_LOADQ = 3'b111
   } psp_op_e;

   // Memory request from processor to bus
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } psp_mreq_s;

   // Instruction fields
   typedef struct packed {
      logic [8:0] opcode;
      logic [3:0] acc;
      logic indirect;
      logic [3:0] index;
   } psp_instr_s;
endpackage

// ---- testbench/psp_core_asserts.sv ----
/*
 Checker for the guarded memory-request ports of psp_core.
 Assumes it is bound to psp_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module psp_core_asserts
   import psp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_ready,
   input wire logic end_instr,
   input wire logic store_arith,
   input wire psp_mreq_s mreq,
   input wire logic mem_error
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Requests made while one is held are dropped, so only free slots count
   wire logic free_slot = !mreq.valid || mem_ready;

   AST_ANSWER: assert property (mem_req && free_slot |=> mreq.valid != mem_error)
      else $error("request gave neither a cycle nor an error");
   AST_ERR_CAUSE: assert property (mem_error |-> $past(mem_req))
      else $error("error without a request");
   AST_NO_CYCLE: assert property (mem_error && $past(free_slot) |-> !mreq.valid)
      else $error("blocked request still reached memory");
   AST_OFFSET: assert property (mem_req && free_slot |=>
      !mreq.valid || mreq.addr[OFF_W-1:0] == $past(mem_addr[OFF_W-1:0]))
      else $error("low address bits altered");
   AST_RELOC_OR: assert property (mem_req && free_slot |=>
      !mreq.valid || (mreq.addr[17:9] & $past(mem_addr[17:9])) == $past(mem_addr[17:9]))
      else $error("original page bits lost");
   AST_WRITE: assert property (mem_req && free_slot |=>
      !mreq.valid || mreq.write == $past(mem_write))
      else $error("request direction wrong");
   AST_HOLD: assert property (mreq.valid && !mem_ready |=> mreq.valid && $stable(mreq))
      else $error("request dropped before acceptance");
   AST_WB: assert property (end_instr && store_arith |->
      ##[1:40] ((mreq.valid && mreq.write) || mem_error))
      else $error("no writeback after end of instruction");
endmodule
bind psp_core psp_core_asserts psp_core_asserts_i (.hclk(hclk), .hresetn(hresetn),
   .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_ready(mem_ready),
   .end_instr(end_instr), .store_arith(store_arith), .mreq(mreq), .mem_error(mem_error));
`default_nettype wire

// ---- testbench/psp_core_tb.sv ----
/*
 Self-checking bench for psp_core with a core memory model.
 Assumes the AHB-Lite slave answers with zero wait and registered requests.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t: got %h want %h", $time, a, b); end end
module psp_core_tb
   import psp_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dphase = 0, err;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, exp_rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'b010, delay = 0;
   logic hreadyout, hresp, irq, mem_ack, mem_ready, mem_error;
   logic mem_req = 0, mem_write = 0, load_instr = 0, step_load = 0, fexp_load = 0;
   logic pc_step = 0, pc_skip = 0, pc_jump = 0, io_attempt = 0, halt_attempt = 0;
   logic end_instr = 0, store_arith = 0, store_mq = 0;
   logic [17:0] mem_addr = 0, a;
   logic [35:0] mem_rdata, rdata_in = 0;
   logic [55:0] exp_m;
   psp_op_e op = PSP_OP_NONE;
   psp_mreq_s mreq;
   logic [31:0] rd_q[$];
   logic [55:0] mq_q[$];
   int fail_count = 0, n_compared = 0, seed = 32'h2bd5_3598;

   always #5 hclk = ~hclk;

   psp_core psp_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .mem_req(mem_req),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .load_instr(load_instr), .op(op), .step_load(step_load), .step_value(9'h003),
      .fexp_load(fexp_load), .fexp_value(9'h1a5), .pc_step(pc_step), .pc_target(18'h0_0123),
      .pc_skip(pc_skip), .pc_jump(pc_jump), .io_attempt(io_attempt),
      .halt_attempt(halt_attempt), .end_instr(end_instr), .store_arith(store_arith),
      .store_mq(store_mq), .mem_ready(mem_ready), .mreq(mreq), .mem_error(mem_error));
   psp_mem_model psp_mem_model_i (.hclk(hclk), .hresetn(hresetn), .mreq(mreq),
      .delay(delay), .rdata_in(rdata_in), .mem_ready(mem_ready), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));

   // Results are paired with the oldest note as they appear
   always @(posedge hclk) begin
      if (rd_dphase && hreadyout) begin
         exp_rd = rd_q.pop_front();
         `CHK(hrdata, exp_rd)
      end
      if ((mreq.valid && mem_ready) || mem_error) begin
         exp_m = mq_q.pop_front();
         `CHK(mem_error, exp_m[55])
         if (!exp_m[55]) `CHK({mreq.write, mreq.addr}, exp_m[54:36])
         if (exp_m[54]) `CHK(mreq.data, exp_m[35:0])
      end
   end

   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h00_0000, ad};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_dphase <= !wr;
      if (!wr) rd_q.push_back(d);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dphase <= 1'b0;
   endtask

   task automatic wait_mem(input int lim);
      for (int n = 0; n < lim && mq_q.size() > 0; n++) @(posedge hclk);
      if (mq_q.size() > 0) begin
         fail_count++;
         $display("[ERR] %0t: memory result missing", $time);
         mq_q.delete();
      end
   endtask

   task automatic mem(input logic wr, input logic [17:0] ad, input logic [55:0] e);
      mq_q.push_back(e);
      @(posedge hclk);
      mem_req <= 1'b1;
      mem_write <= wr;
      mem_addr <= ad;
      @(posedge hclk);
      mem_req <= 1'b0;
      wait_mem(40);
      repeat (2) @(posedge hclk);
   endtask

   task automatic opx(input psp_op_e o);
      @(posedge hclk);
      op <= o;
      @(posedge hclk);
      op <= PSP_OP_NONE;
   endtask

   task automatic pcs(input logic s, input logic j);
      @(posedge hclk);
      pc_step <= 1'b1;
      pc_skip <= s;
      pc_jump <= j;
      @(posedge hclk);
      pc_step <= 1'b0;
   endtask

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #300000;
      fail_count++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, OFF_CTRL, 32'h0000_0001);
      ahb(0, 8'h80, 32'h0000_0000);
      ahb(1, OFF_SWADDR, 32'h0003_f123);
      ahb(1, OFF_PROT, 32'h0000_01ff);
      ahb(1, OFF_RELOC, 32'h0000_00a5);
      rdata_in <= 36'h5_a5a5_0f0f;
      mem(1'b0, 18'h3_f123, {2'b00, 18'h3_f123, 36'h0});
      ahb(0, OFF_IND_LO, 32'ha5a5_0f0f);
      ahb(0, OFF_IND_HI, 32'h0000_0005);
      $display("supervisor access test done");
      ahb(1, OFF_PROT, 32'h0000_01f0);
      ahb(1, OFF_RELOC, 32'h0000_0100);
      for (int i = 0; i < 8; i++) begin
         a = 18'($random(seed));
         if (i % 2 == 1) a[17:13] = 5'h00;
         err = (a[17:9] & 9'h1f0) != 9'h000;
         delay <= 3'(i % 4);
         ahb(1, OFF_CTRL, 32'h0000_0002);
         mem(a[0], a, {err, a[0], a[17:9] | 9'h100, a[8:0], 36'h0});
         ahb(0, OFF_CTRL, err ? 32'h0000_0003 : 32'h0000_0002);
      end
      $display("user protection test done");
      ahb(1, OFF_STATUS, 32'h0000_000f);
      for (int k = 0; k < 2; k++) begin
         ahb(1, OFF_MASK, 32'h0000_0002);
         ahb(1, OFF_CTRL, 32'h0000_0000);
         @(posedge hclk);
         io_attempt <= (k == 0);
         halt_attempt <= (k == 1);
         @(posedge hclk);
         io_attempt <= 1'b0;
         halt_attempt <= 1'b0;
         @(posedge hclk);
         `CHK(irq, 1'b1)
         ahb(0, OFF_CTRL, 32'h0000_0001);
         ahb(1, OFF_MASK, 32'h0000_0000);
         @(posedge hclk);
         `CHK(irq, 1'b0)
         ahb(1, OFF_MASK, 32'h0000_0002);
         ahb(1, OFF_STATUS, 32'h0000_0002);
         @(posedge hclk);
         `CHK(irq, 1'b0)
      end
      $display("trap and interrupt test done");
      pcs(1'b0, 1'b0);
      ahb(0, OFF_FLAGS, 32'h0000_0000);
      pcs(1'b1, 1'b0);
      ahb(0, OFF_PC, 32'h0000_0003);
      ahb(0, OFF_FLAGS, 32'h0000_0008);
      pcs(1'b0, 1'b1);
      ahb(0, OFF_PC, 32'h0000_0123);
      rdata_in <= 36'h4_0000_0000;
      mem(1'b0, 18'h0_0200, {2'b00, 18'h0_0200, 36'h0});
      opx(PSP_OP_ADD);
      opx(PSP_OP_ADD);
      ahb(0, OFF_FLAGS, 32'h0000_000e);
      rdata_in <= 36'h8_0000_0000;
      mem(1'b0, 18'h0_0201, {2'b00, 18'h0_0201, 36'h0});
      opx(PSP_OP_ADD);
      ahb(0, OFF_FLAGS, 32'h0000_000f);
      ahb(0, OFF_ARITH_HI, 32'h0000_0000);
      $display("flag test done");
      rdata_in <= 36'h0_0280_0000;
      mem(1'b0, 18'h0_0202, {2'b00, 18'h0_0202, 36'h0});
      @(posedge hclk);
      load_instr <= 1'b1;
      fexp_load <= 1'b1;
      @(posedge hclk);
      load_instr <= 1'b0;
      fexp_load <= 1'b0;
      opx(PSP_OP_LOADQ);
      @(posedge hclk);
      step_load <= 1'b1;
      @(posedge hclk);
      step_load <= 1'b0;
      ahb(0, OFF_INSTR, 32'h0000_00a0);
      ahb(0, OFF_MQ_LO, 32'h0280_0000);
      ahb(0, OFF_STEP, 32'h0000_0003);
      ahb(0, OFF_FEXP, 32'h0000_01a5);
      mq_q.push_back({2'b01, 18'h0_0005, 36'h0});
      mq_q.push_back({2'b01, 18'h0_0005, 36'h0_0280_0000});
      @(posedge hclk);
      end_instr <= 1'b1;
      store_arith <= 1'b1;
      store_mq <= 1'b1;
      @(posedge hclk);
      end_instr <= 1'b0;
      wait_mem(60);
      $display("writeback test done");
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, OFF_CTRL, 32'h0000_0001);
      $display("second reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- testbench/psp_mem_model.sv ----
/*
 Behavioural core memory module for the processor-memory bus.
 Assumes one request at a time; delay sets the wait before acceptance.
*/
`timescale 1ns/1ps
`default_nettype none
module psp_mem_model
   import psp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire psp_mreq_s mreq,
   input wire logic [2:0] delay,
   input wire logic [WORD_W-1:0] rdata_in,
   output logic mem_ready,
   output logic mem_ack,
   output logic [WORD_W-1:0] mem_rdata
);
   logic [2:0] wait_cnt;
   assign mem_ready = mreq.valid && (wait_cnt >= delay);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_cnt <= 3'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 36'h0;
      end else begin
         wait_cnt <= (mreq.valid && !mem_ready) ? wait_cnt + 3'h1 : 3'h0;
         mem_ack <= mem_ready && !mreq.write;
         // Stale data flips so nothing can lean on it
         mem_rdata <= (mem_ready && !mreq.write) ? rdata_in : ~mem_rdata;
      end
   end
endmodule
`default_nettype wire
